/* include/cpurf_map.svh */
/*
 * Constants for the CPU register file: flag positions, reset values,
 * step sizes and BCD adjust figures.
 * Assumes it is included by bare name, before the package and modules.
 */
// What this block does
// - Sixteen byte registers that pair into eight word registers.
// - Word registers read/written whole, or each byte half on its own.
// - Register used as a memory address is always the full word.
// - Word register seven is the stack pointer, top of stack.
// - Word program counter holds next address; its low bit reads zero.
// - Mask bit seven blocks interrupts; set when exception handling starts.
// - Flag bits six and four are free user storage.
// - Byte add/sub/cmp/neg: half-carry is carry or borrow out of bit 3.
// - Word add/sub/cmp: half-carry is carry or borrow out of bit 11.
// - Negative bit copies the result sign bit.
// - Zero bit set on zero result, cleared otherwise.
// - Overflow bit set on signed overflow, cleared otherwise.
// - Carry holds add carry, borrow, shift-out, and bit accumulator.
// - Branch conditions use negative, zero, overflow and carry.
// - Flags readable and writable by load, store, and, or, xor.
// - Reset loads counter from vector word zero and sets mask bit.
// - Word access at odd address uses the preceding even address.
// - Flags pushed as doubled word; restore uses only upper byte.
// - Bit operands pick bit zero to seven of a byte.
// - Decimal adjust treats a byte as two BCD digits using half-carry.
// - Addresses are sixteen bits, one 64 kbyte space.
// - Common instructions complete in two to four states.
`ifndef CPURF_MAP_SVH
`define CPURF_MAP_SVH
`define CPURF_VEC_RESET 16'h0000
`define CPURF_FLAGS_RST 8'h80
`define CPURF_FLG_I 7
`define CPURF_FLG_U6 6
`define CPURF_FLG_H 5
`define CPURF_FLG_U4 4
`define CPURF_FLG_N 3
`define CPURF_FLG_Z 2
`define CPURF_FLG_V 1
`define CPURF_FLG_C 0
`define CPURF_SP_IDX 3'h7
`define CPURF_WORD_STEP 16'h0002
`define CPURF_BCD_DIGIT_MAX 4'h9
`define CPURF_BCD_BYTE_MAX 8'h99
`define CPURF_BCD_ADJ_LO 8'h06
`define CPURF_BCD_ADJ_HI 8'h60
`endif

/* include/cpurf_pkg.sv */
/*
 * Types for the CPU register file: operation codes and states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpurf_pkg;
	// Flag-producing operations requested by the execution datapath
	typedef enum logic [3:0] {
		FOP_ADD, FOP_ADDX, FOP_SUB, FOP_SUBX, FOP_CMP, FOP_NEG,
		FOP_DAA, FOP_DAS, FOP_LOGIC, FOP_SHIFT
	} cpurf_fop_t;
	// Software accesses to the flag register
	typedef enum logic [2:0] {
		CCR_LOAD, CCR_AND, CCR_OR, CCR_XOR, CCR_RESTORE
	} cpurf_ccr_op_t;
	// Bit accumulator operations on the carry flag
	typedef enum logic [1:0] {
		BOP_LOAD, BOP_AND, BOP_OR, BOP_XOR
	} cpurf_bop_t;
	// Branch conditions, in the usual four-bit order
	typedef enum logic [3:0] {
		CND_T, CND_F, CND_HI, CND_LS, CND_CC, CND_CS, CND_NE, CND_EQ,
		CND_VC, CND_VS, CND_PL, CND_MI, CND_GE, CND_LT, CND_GT, CND_LE
	} cpurf_cond_t;
	typedef enum logic {ST_VEC, ST_RUN} cpurf_state_t;
endpackage : cpurf_pkg

/* rtl/cpurf_core_regs.sv */
/*
 * CPU architectural state: general registers, stack pointer, program
 * counter and flag register, with reset vector fetch and flag updates.
 * Assumes the execution datapath on the same clock drives all requests
 * and reads the registered results one cycle later.
 */
`timescale 1ns/1ns
`include "cpurf_map.svh"
module cpurf_core_regs #(
	parameter int NREG = 8
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic gp_wr_en,
	input wire logic gp_wr_word,
	input wire logic [3:0] gp_wr_sel,
	input wire logic [15:0] gp_wr_data,
	input wire logic gp_rd_word,
	input wire logic [3:0] gp_rd_sel,
	output logic [15:0] gp_rd_data,
	input wire logic [2:0] addr_sel,
	input wire logic addr_word_acc,
	output logic [15:0] ea_addr,
	input wire logic sp_adj_en,
	input wire logic sp_adj_down,
	output logic [15:0] sp_value,
	input wire logic pc_load_en,
	input wire logic [15:0] pc_load_val,
	input wire logic pc_step_en,
	output logic [15:0] pc_value,
	output logic vec_req,
	output logic [15:0] vec_addr,
	input wire logic vec_ack,
	input wire logic [15:0] vec_data,
	input wire logic alu_en,
	input wire cpurf_pkg::cpurf_fop_t alu_op,
	input wire logic alu_word,
	input wire logic [15:0] alu_a,
	input wire logic [15:0] alu_b,
	input wire logic alu_ext_c,
	input wire logic alu_ext_v,
	input wire logic ccr_en,
	input wire cpurf_pkg::cpurf_ccr_op_t ccr_op,
	input wire logic [15:0] ccr_data,
	input wire logic exc_start,
	input wire logic bit_en,
	input wire cpurf_pkg::cpurf_bop_t bit_op,
	input wire logic bit_invert,
	input wire logic [2:0] bit_idx,
	input wire logic [7:0] bit_byte,
	input wire cpurf_pkg::cpurf_cond_t cond_sel,
	output logic cond_true,
	output logic [7:0] flags,
	output logic [15:0] flags_stack_word,
	output logic irq_masked,
	output logic core_ready
);
	localparam int IW = $clog2(NREG);

	// Word-align an address for any word access
	function automatic logic [15:0] align_word(input logic [15:0] ad);
		align_word = {ad[15:1], 1'b0};
	endfunction : align_word

	// Merge a byte or word write into a stored word
	function automatic logic [15:0] merge(input logic [15:0] old,
			input logic wd, input logic lo, input logic [15:0] d);
		if (wd)
			merge = d;
		else if (lo)
			merge = {old[15:8], d[7:0]};
		else
			merge = {d[7:0], old[7:0]};
	endfunction : merge

	// Branch condition from the flag byte
	function automatic logic cond_eval(input cpurf_pkg::cpurf_cond_t cs,
			input logic [7:0] f);
		logic n;
		logic z;
		logic v;
		logic c;
		n = f[`CPURF_FLG_N];
		z = f[`CPURF_FLG_Z];
		v = f[`CPURF_FLG_V];
		c = f[`CPURF_FLG_C];
		unique case (cs)
			cpurf_pkg::CND_T: cond_eval = 1'b1;
			cpurf_pkg::CND_F: cond_eval = 1'b0;
			cpurf_pkg::CND_HI: cond_eval = ~(c | z);
			cpurf_pkg::CND_LS: cond_eval = c | z;
			cpurf_pkg::CND_CC: cond_eval = ~c;
			cpurf_pkg::CND_CS: cond_eval = c;
			cpurf_pkg::CND_NE: cond_eval = ~z;
			cpurf_pkg::CND_EQ: cond_eval = z;
			cpurf_pkg::CND_VC: cond_eval = ~v;
			cpurf_pkg::CND_VS: cond_eval = v;
			cpurf_pkg::CND_PL: cond_eval = ~n;
			cpurf_pkg::CND_MI: cond_eval = n;
			cpurf_pkg::CND_GE: cond_eval = ~(n ^ v);
			cpurf_pkg::CND_LT: cond_eval = n ^ v;
			cpurf_pkg::CND_GT: cond_eval = ~(z | (n ^ v));
			cpurf_pkg::CND_LE: cond_eval = z | (n ^ v);
		endcase
	endfunction : cond_eval

	// Reset release through two flops; assertion stays asynchronous
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire rst_n = rst_sync_reg;

	// General registers: no reset, contents are undefined until written
	logic [15:0] gpr_reg [NREG];
	logic [15:0] pc_reg;
	logic [7:0] flags_reg;
	cpurf_pkg::cpurf_state_t state_reg;
	cpurf_pkg::cpurf_state_t state_next;

	// Flag calculator; its result goes to the write-select register
	logic [15:0] alu_res;
	logic [7:0] alu_flg;
	logic [7:0] alu_upd;
	logic alu_res_wr;
	cpurf_flag_calc u_flag_calc (
		.op(alu_op),
		.word(alu_word),
		.a(alu_a),
		.b(alu_b),
		.c_in(flags_reg[`CPURF_FLG_C]),
		.h_in(flags_reg[`CPURF_FLG_H]),
		.ext_c(alu_ext_c),
		.ext_v(alu_ext_v),
		.res(alu_res),
		.flg(alu_flg),
		.upd(alu_upd),
		.res_wr(alu_res_wr)
	);

	// Single write port: an arithmetic result takes it over a plain write
	wire running = (state_reg == cpurf_pkg::ST_RUN);
	wire alu_wr = running && alu_en && alu_res_wr;
	wire wr_go = alu_wr || (running && gp_wr_en && !alu_en);
	wire [15:0] wr_val = alu_wr ? alu_res : gp_wr_data;
	wire wr_wd = alu_wr ? alu_word : gp_wr_word;
	wire [IW-1:0] wr_ix = gp_wr_sel[IW-1:0];
	wire wr_lo = gp_wr_sel[3]; // Selector bit 3 picks the lower byte

	// Stack pointer step by one word; a write to it the same cycle wins
	wire [IW-1:0] sp_ix = IW'(`CPURF_SP_IDX);
	wire [15:0] sp_cur = gpr_reg[sp_ix];
	wire [15:0] sp_step = sp_adj_down ? (sp_cur - `CPURF_WORD_STEP)
		: (sp_cur + `CPURF_WORD_STEP);
	wire sp_go = running && sp_adj_en && !(wr_go && wr_ix == sp_ix);

	// Register write path
	always_ff @(posedge sys_clk) begin
		if (wr_go)
			gpr_reg[wr_ix] <= merge(gpr_reg[wr_ix], wr_wd, wr_lo,
				wr_val);
		if (sp_go)
			gpr_reg[sp_ix] <= sp_step;
	end

	// Read selection; byte reads land in the low bits
	wire [15:0] rd_w = gpr_reg[gp_rd_sel[IW-1:0]];
	wire [15:0] rd_val = gp_rd_word ? rd_w
		: {8'h00, gp_rd_sel[3] ? rd_w[7:0] : rd_w[15:8]};
	wire [15:0] ea_raw = gpr_reg[addr_sel[IW-1:0]];
	wire [15:0] ea_val = addr_word_acc ? align_word(ea_raw) : ea_raw;

	// Reset sequence: fetch the vector word, then run
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cpurf_pkg::ST_VEC: if (vec_ack)
				state_next = cpurf_pkg::ST_RUN;
			cpurf_pkg::ST_RUN: state_next = cpurf_pkg::ST_RUN;
		endcase
	end

	// Program counter: vector load, jump load or one-word step
	logic [15:0] pc_next;
	always_comb begin
		pc_next = pc_reg;
		if (!running && vec_ack)
			pc_next = align_word(vec_data);
		else if (running && pc_load_en)
			pc_next = align_word(pc_load_val);
		else if (running && pc_step_en)
			pc_next = pc_reg + `CPURF_WORD_STEP;
	end

	// Bit accumulator on carry, bit picked by index
	wire sel_bit = bit_byte[bit_idx] ^ bit_invert;
	logic acc_c;
	always_comb begin
		unique case (bit_op)
			cpurf_pkg::BOP_LOAD: acc_c = sel_bit;
			cpurf_pkg::BOP_AND: acc_c = flags_reg[`CPURF_FLG_C] & sel_bit;
			cpurf_pkg::BOP_OR: acc_c = flags_reg[`CPURF_FLG_C] | sel_bit;
			cpurf_pkg::BOP_XOR: acc_c = flags_reg[`CPURF_FLG_C] ^ sel_bit;
		endcase
	end

	// Flag update; software access first, then arithmetic, then bit ops.
	// Exception entry is applied last so the mask cannot be lost.
	logic [7:0] flags_next;
	always_comb begin
		flags_next = flags_reg;
		if (running && ccr_en) begin
			unique case (ccr_op)
				cpurf_pkg::CCR_LOAD: flags_next = ccr_data[7:0];
				cpurf_pkg::CCR_AND: flags_next = flags_reg & ccr_data[7:0];
				cpurf_pkg::CCR_OR: flags_next = flags_reg | ccr_data[7:0];
				cpurf_pkg::CCR_XOR: flags_next = flags_reg ^ ccr_data[7:0];
				cpurf_pkg::CCR_RESTORE:
					flags_next = ccr_data[15:8];
				default: flags_next = flags_reg;
			endcase
		end else if (running && alu_en) begin
			flags_next = (flags_reg & ~alu_upd) | (alu_flg & alu_upd);
		end else if (running && bit_en) begin
			flags_next[`CPURF_FLG_C] = acc_c;
		end
		if (running && exc_start)
			flags_next[`CPURF_FLG_I] = 1'b1;
	end

	// Control state, program counter and flag register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= cpurf_pkg::ST_VEC;
			pc_reg <= `CPURF_VEC_RESET;
			flags_reg <= `CPURF_FLAGS_RST;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			flags_reg <= flags_next;
		end
	end

	// Output copies, each from its own flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gp_rd_data <= 16'h0000;
			ea_addr <= 16'h0000;
			sp_value <= 16'h0000;
			pc_value <= `CPURF_VEC_RESET;
			vec_req <= 1'b0;
			vec_addr <= `CPURF_VEC_RESET;
			cond_true <= 1'b0;
			flags <= `CPURF_FLAGS_RST;
			flags_stack_word <= {`CPURF_FLAGS_RST, `CPURF_FLAGS_RST};
			irq_masked <= 1'b1;
			core_ready <= 1'b0;
		end else begin
			gp_rd_data <= rd_val;
			ea_addr <= ea_val;
			sp_value <= sp_cur;
			pc_value <= align_word(pc_next);
			vec_req <= (state_next == cpurf_pkg::ST_VEC);
			vec_addr <= `CPURF_VEC_RESET;
			cond_true <= cond_eval(cond_sel, flags_next);
			flags <= flags_next;
			flags_stack_word <= {flags_next, flags_next};
			irq_masked <= flags_next[`CPURF_FLG_I];
			core_ready <= (state_next == cpurf_pkg::ST_RUN);
		end
	end

	// Each register request is accepted in one cycle, which leaves the
	// two-to-four state budget of common instructions to the datapath.
endmodule : cpurf_core_regs

/* rtl/cpurf_flag_calc.sv */
/*
 * Arithmetic flag calculator: sum, difference, negate and decimal
 * adjust with their flags, plus flag forms for logic and shift results.
 * Assumes the caller registers the outputs; purely combinational.
 */
`timescale 1ns/1ns
`include "cpurf_map.svh"
module cpurf_flag_calc (
	input wire cpurf_pkg::cpurf_fop_t op,
	input wire logic word,
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	input wire logic c_in,
	input wire logic h_in,
	input wire logic ext_c,
	input wire logic ext_v,
	output logic [15:0] res,
	output logic [7:0] flg,
	output logic [7:0] upd,
	output logic res_wr
);
	wire is_neg = (op == cpurf_pkg::FOP_NEG);
	wire is_sub = (op == cpurf_pkg::FOP_SUB) || (op == cpurf_pkg::FOP_SUBX)
		|| (op == cpurf_pkg::FOP_CMP) || is_neg;
	wire with_c = (op == cpurf_pkg::FOP_ADDX) || (op == cpurf_pkg::FOP_SUBX);
	wire is_arith = is_sub || (op == cpurf_pkg::FOP_ADD) || with_c;
	// Byte operands are zero-extended so bit 8 carries the byte carry
	wire [15:0] opa = is_neg ? 16'h0000 : (word ? a : {8'h00, a[7:0]});
	wire [15:0] opb = is_neg ? (word ? a : {8'h00, a[7:0]})
		: (word ? b : {8'h00, b[7:0]});
	wire [16:0] ci = {16'h0000, with_c & c_in};
	wire [16:0] r17 = is_sub ? ({1'b0, opa} - {1'b0, opb} - ci)
		: ({1'b0, opa} + {1'b0, opb} + ci);
	// Per-bit carry-in vector: carry or borrow into bit k+1 sits at k+1
	wire [15:0] cvec = opa ^ opb ^ r17[15:0];
	wire s_a = word ? opa[15] : opa[7];
	wire s_b = word ? opb[15] : opb[7];
	wire s_r = word ? r17[15] : r17[7];
	// Decimal adjust on the low byte
	wire lo_fix = (a[3:0] > `CPURF_BCD_DIGIT_MAX) || h_in;
	wire hi_fix = (a[7:0] > `CPURF_BCD_BYTE_MAX) || c_in;
	wire [7:0] adj = (lo_fix ? `CPURF_BCD_ADJ_LO : 8'h00)
		| (hi_fix ? `CPURF_BCD_ADJ_HI : 8'h00);
	wire [7:0] bcd = (op == cpurf_pkg::FOP_DAS) ? (a[7:0] - adj)
		: (a[7:0] + adj);
	wire is_bcd = (op == cpurf_pkg::FOP_DAA) || (op == cpurf_pkg::FOP_DAS);

	// Result select and flag forming
	always_comb begin
		res = a;
		flg = 8'h00;
		upd = 8'h00;
		res_wr = (op != cpurf_pkg::FOP_CMP);
		if (is_arith) begin
			res = r17[15:0];
			flg[`CPURF_FLG_H] = word ? cvec[12] : cvec[4];
			flg[`CPURF_FLG_V] = (is_sub ? (s_a != s_b) : (s_a == s_b))
				&& (s_r != s_a);
			flg[`CPURF_FLG_C] = word ? r17[16] : r17[8];
			upd = 8'h2F;
		end else if (is_bcd) begin
			res = {8'h00, bcd};
			flg[`CPURF_FLG_C] = hi_fix;
			upd = 8'h0D;
		end else if (op == cpurf_pkg::FOP_SHIFT) begin
			flg[`CPURF_FLG_C] = ext_c;
			flg[`CPURF_FLG_V] = ext_v;
			upd = 8'h0F;
		end else begin
			upd = 8'h0E;
		end
		flg[`CPURF_FLG_N] = word ? res[15] : res[7];
		flg[`CPURF_FLG_Z] = word ? (res == 16'h0000)
			: (res[7:0] == 8'h00);
	end
endmodule : cpurf_flag_calc

/* verif/cpurf_core_regs_asserts.sv */
/* Port checker for the CPU register file.
   Assumes a bind onto cpurf_core_regs, single clock. */
`timescale 1ns/1ns
module cpurf_core_regs_asserts (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic core_ready,
	input wire logic exc_start,
	input wire logic [7:0] flags,
	input wire logic irq_masked,
	input wire logic [15:0] flags_stack_word,
	input wire logic [15:0] pc_value,
	input wire logic pc_load_en,
	input wire logic [15:0] pc_load_val,
	input wire logic vec_req,
	input wire logic vec_ack,
	input wire logic [15:0] vec_data,
	input wire logic ccr_en,
	input wire cpurf_pkg::cpurf_ccr_op_t ccr_op,
	input wire logic [15:0] ccr_data,
	input wire cpurf_pkg::cpurf_cond_t cond_sel,
	input wire logic cond_true
);
	// One domain, so clock and reset are given once
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	property p_pc_even;
		pc_value[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc odd");
	property p_stack;
		flags_stack_word == {flags, flags};
	endproperty
	a_stack: assert property (p_stack) else $error("stack image");
	property p_mask;
		irq_masked == flags[7];
	endproperty
	a_mask: assert property (p_mask) else $error("mask output");
	property p_exc;
		core_ready && exc_start |=> flags[7] ##1 flags[7];
	endproperty
	a_exc: assert property (p_exc) else $error("exc mask");
	property p_pc_load;
		core_ready && pc_load_en |=>
			pc_value == {$past(pc_load_val[15:1]), 1'b0};
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("pc load");
	property p_vec;
		vec_req && vec_ack |=> core_ready && !vec_req &&
			pc_value == {$past(vec_data[15:1]), 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector");
	property p_ccr_load;
		core_ready && ccr_en && ccr_op == cpurf_pkg::CCR_LOAD && !exc_start
			|=> flags == $past(ccr_data[7:0]);
	endproperty
	a_ccr_load: assert property (p_ccr_load) else $error("flag load");
	property p_cond_eq;
		core_ready && $past(cond_sel) == cpurf_pkg::CND_EQ |->
			cond_true == flags[2];
	endproperty
	a_cond_eq: assert property (p_cond_eq) else $error("branch eq");
endmodule : cpurf_core_regs_asserts
bind cpurf_core_regs cpurf_core_regs_asserts i_cpurf_core_regs_asserts (
	.sys_clk, .resetn, .core_ready, .exc_start, .flags, .irq_masked,
	.flags_stack_word, .pc_value, .pc_load_en, .pc_load_val, .vec_req,
	.vec_ack, .vec_data, .ccr_en, .ccr_op, .ccr_data, .cond_sel, .cond_true
);

/* verif/cpurf_core_regs_test.sv */
/* Self-checking bench for the CPU register file.
   Assumes the datapath model answers the vector fetch. */
`timescale 1ns/1ns
module cpurf_core_regs_test;
	logic sys_clk = 0, resetn = 0, gp_wr_en = 0, gp_wr_word = 0;
	logic [3:0] gp_wr_sel = 0, gp_rd_sel = 0;
	logic [15:0] gp_wr_data = 0, alu_a = 0, alu_b = 0, ccr_data = 0;
	logic [15:0] pc_load_val = 0, gp_rd_data, ea_addr, sp_value, pc_value;
	logic gp_rd_word = 0, addr_word_acc = 0, sp_adj_en = 0, pc_load_en = 0;
	logic pc_step_en = 0, alu_en = 0, alu_word = 0, ccr_en = 0, bit_en = 0;
	logic exc_start = 0, vec_req, vec_ack, cond_true, irq_masked, core_ready;
	logic [2:0] addr_sel = 0, bit_idx = 0;
	logic [7:0] bit_byte = 0, flags;
	logic [15:0] vec_addr, vec_data, flags_stack_word;
	cpurf_pkg::cpurf_fop_t alu_op = cpurf_pkg::FOP_ADD;
	cpurf_pkg::cpurf_ccr_op_t ccr_op = cpurf_pkg::CCR_LOAD;
	cpurf_pkg::cpurf_bop_t bit_op = cpurf_pkg::BOP_LOAD;
	int n_fail = 0, n_compared = 0;
	always #10 sys_clk = ~sys_clk;
	// Fixed inputs: down-stepping stack, no shift extras, EQ branch
	cpurf_core_regs i_cpurf_core_regs (.sys_clk, .resetn, .gp_wr_en,
		.gp_wr_word, .gp_wr_sel, .gp_wr_data, .gp_rd_word, .gp_rd_sel,
		.gp_rd_data, .addr_sel, .addr_word_acc, .ea_addr, .sp_adj_en,
		.sp_adj_down(1'b1), .sp_value, .pc_load_en, .pc_load_val,
		.pc_step_en, .pc_value, .vec_req, .vec_addr, .vec_ack, .vec_data,
		.alu_en, .alu_op, .alu_word, .alu_a, .alu_b, .alu_ext_c(1'b0),
		.alu_ext_v(1'b0), .ccr_en, .ccr_op, .ccr_data, .exc_start, .bit_en,
		.bit_op, .bit_invert(1'b0), .bit_idx, .bit_byte,
		.cond_sel(cpurf_pkg::CND_EQ), .cond_true, .flags, .flags_stack_word,
		.irq_masked, .core_ready);
	cpurf_dp_model i_cpurf_dp_model (.sys_clk, .vec_req, .vec_ack, .vec_data);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// Sample edge, then an idle edge so no signal is set twice at once
	task automatic step;
		@(posedge sys_clk);
		{gp_wr_en, alu_en, ccr_en, exc_start} <= 4'h0;
		{bit_en, sp_adj_en, pc_load_en, pc_step_en} <= 4'h0;
		@(posedge sys_clk);
	endtask : step
	task automatic wr(input logic w, input logic [3:0] s, input logic [15:0] d);
		gp_wr_en <= 1'b1;
		gp_wr_word <= w;
		gp_wr_sel <= s;
		gp_wr_data <= d;
		step;
	endtask : wr
	task automatic rd(input logic w, input logic [3:0] s, input logic [15:0] e);
		gp_rd_word <= w;
		gp_rd_sel <= s;
		step;
		chk(gp_rd_data, e);
	endtask : rd
	task automatic condition_flags(input cpurf_pkg::cpurf_ccr_op_t o, input logic [15:0] d);
		ccr_en <= 1'b1;
		ccr_op <= o;
		ccr_data <= d;
		step;
	endtask : condition_flags
	// Flags start from zero so every expected bit is the op's own
	task automatic alu(input cpurf_pkg::cpurf_fop_t o, input logic w,
		input logic [15:0] a, input logic [15:0] b, input logic [7:0] f,
		input logic [15:0] r);
		condition_flags(cpurf_pkg::CCR_LOAD, 16'h0000);
		alu_en <= 1'b1;
		alu_op <= o;
		alu_word <= w;
		alu_a <= a;
		alu_b <= b;
		gp_wr_sel <= w ? 4'h0 : 4'h8;
		step;
		chk({8'h00, flags}, {8'h00, f});
		if (o != cpurf_pkg::FOP_CMP)
			rd(w, w ? 4'h0 : 4'h8, r);
	endtask : alu
	task automatic bitld(input logic [2:0] i, input logic [7:0] b);
		bit_en <= 1'b1;
		bit_idx <= i;
		bit_byte <= b;
		step;
	endtask : bitld
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 50 && core_ready !== 1'b1; i++)
			@(posedge sys_clk);
		if (core_ready !== 1'b1) begin
			n_fail++;
			close_out;
		end
		@(posedge sys_clk);
		chk(pc_value, 16'h0100);
		chk({8'h00, flags}, 16'h0080);
		chk(vec_addr, 16'h0000);
		for (int i = 0; i < 16; i++)
			wr(1'b0, i[3:0], 16'(i * 17));
		for (int r = 0; r < 8; r++)
			rd(1'b1, r[3:0], 16'({r * 17, 8'((r + 8) * 17)}));
		wr(1'b1, 4'h2, 16'h1234);
		wr(1'b0, 4'hA, 16'h00AB);
		rd(1'b1, 4'h2, 16'h12AB);
		rd(1'b0, 4'h2, 16'h0012);
		wr(1'b1, 4'h3, 16'h4321);
		addr_sel <= 3'h3;
		addr_word_acc <= 1'b1;
		step;
		chk(ea_addr, 16'h4320);
		addr_word_acc <= 1'b0;
		step;
		chk(ea_addr, 16'h4321);
		wr(1'b1, 4'h7, 16'h1000);
		sp_adj_en <= 1'b1;
		step;
		step;
		chk(sp_value, 16'h0FFE);
		pc_load_en <= 1'b1;
		pc_load_val <= 16'h2345;
		step;
		chk(pc_value, 16'h2344);
		pc_step_en <= 1'b1;
		step;
		chk(pc_value, 16'h2346);
		alu(cpurf_pkg::FOP_ADD, 1'b0, 16'h0F, 16'h01, 8'h20, 16'h10);
		alu(cpurf_pkg::FOP_ADD, 1'b0, 16'h7F, 16'h01, 8'h2A, 16'h80);
		alu(cpurf_pkg::FOP_ADD, 1'b0, 16'hFF, 16'h01, 8'h25, 16'h00);
		alu(cpurf_pkg::FOP_SUB, 1'b0, 16'h10, 16'h01, 8'h20, 16'h0F);
		alu(cpurf_pkg::FOP_CMP, 1'b0, 16'h05, 16'h05, 8'h04, 16'h00);
		chk({15'h0, cond_true}, 16'h0001);
		alu(cpurf_pkg::FOP_NEG, 1'b0, 16'h01, 16'h00, 8'h29, 16'h00FF);
		alu(cpurf_pkg::FOP_ADD, 1'b1, 16'h0F00, 16'h0100, 8'h20, 16'h1000);
		alu(cpurf_pkg::FOP_SUB, 1'b1, 16'h0000, 16'h0001, 8'h29, 16'hFFFF);
		alu(cpurf_pkg::FOP_DAA, 1'b0, 16'h9A, 16'h00, 8'h05, 16'h00);
		for (int i = 0; i < 8; i++) begin
			bitld(i[2:0], 8'h01 << i);
			chk({15'h0, flags[0]}, 16'h0001);
			bitld(i[2:0], ~(8'h01 << i));
			chk({15'h0, flags[0]}, 16'h0000);
		end
		condition_flags(cpurf_pkg::CCR_LOAD, 16'h0050);
		chk({8'h00, flags}, 16'h0050);
		chk({15'h0, cond_true}, 16'h0000);
		condition_flags(cpurf_pkg::CCR_AND, 16'h001F);
		condition_flags(cpurf_pkg::CCR_OR, 16'h0041);
		condition_flags(cpurf_pkg::CCR_XOR, 16'h00FF);
		chk(flags_stack_word, 16'hAEAE);
		condition_flags(cpurf_pkg::CCR_RESTORE, 16'h245A);
		chk({8'h00, flags}, 16'h0024);
		exc_start <= 1'b1;
		step;
		chk({15'h0, irq_masked}, 16'h0001);
		close_out;
	end
endmodule : cpurf_core_regs_test

/* verif/cpurf_dp_model.sv */
/* Datapath-side model that answers the reset vector fetch.
   Assumes the core's sys_clk and vec_req level. */
`timescale 1ns/1ns
module cpurf_dp_model #(
	parameter logic [15:0] VEC_WORD = 16'h0101,
	parameter int DELAY = 3
) (
	input wire logic sys_clk,
	input wire logic vec_req,
	output logic vec_ack,
	output logic [15:0] vec_data
);
	int cnt = 0;
	wire give = vec_req && !vec_ack && cnt == DELAY;
	initial begin
		vec_ack = 1'b0;
		vec_data = ~VEC_WORD;
	end
	// Slow answer; the data bus carries junk outside the ack cycle
	always @(posedge sys_clk) begin
		cnt <= vec_req ? cnt + 1 : 0;
		vec_ack <= give;
		vec_data <= give ? VEC_WORD : ~vec_data;
	end
endmodule : cpurf_dp_model
